// ===== rtl/iuvw_lin11_dec.sv
// Linear-11 decoder with volt range check
`timescale 1ns/1ps
module iuvw_lin11_dec (
  input wire iuvw_pkg::iuvw_code_t code,
  output iuvw_pkg::iuvw_fix_t value,
  output logic in_range
);
  import iuvw_pkg::*;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Exponent range keeps the shift non-negative, so no bits are lost
  always_comb begin
    value = iuvw_lin11_fix(code);
    in_range = (value >= IUVW_FIX_MIN) && (value <= IUVW_FIX_MAX);
  end

endmodule : iuvw_lin11_dec

// ===== rtl/iuvw_pkg.sv
// Package of constants for the input low-voltage warning threshold block
package iuvw_pkg;

  // ----------------------------------------------------------------
  // Command and register
  // ----------------------------------------------------------------
  localparam logic [7:0] IUVW_CMD_CODE = 8'h58;
  localparam logic [15:0] IUVW_THR_RESET = 16'hcb80;
  localparam int IUVW_DATA_W = 16;

  // ----------------------------------------------------------------
  // Linear-11 field layout
  // ----------------------------------------------------------------
  localparam int IUVW_EXP_MSB = 15;
  localparam int IUVW_EXP_LSB = 11;
  localparam int IUVW_MANT_MSB = 10;
  localparam int IUVW_FIX_W = 48;
  localparam logic signed [5:0] IUVW_FIX_FRAC = 6'sh10;
  // 16 V in fixed point with 16 fraction bits
  localparam logic signed [47:0] IUVW_FIX_MAX = 48'sh0000_0010_0000;
  localparam logic signed [47:0] IUVW_FIX_MIN = 48'sh0000_0000_0000;

  // ----------------------------------------------------------------
  // Fault response fields
  // ----------------------------------------------------------------
  localparam int IUVW_RESP_MODE_MSB = 7;
  localparam int IUVW_RESP_MODE_LSB = 6;
  localparam logic [1:0] IUVW_RESP_MODE_RETRY = 2'h2;
  localparam int IUVW_RESP_RETRY_MSB = 5;
  localparam int IUVW_RESP_RETRY_LSB = 3;

  // ----------------------------------------------------------------
  // Status bit positions
  // ----------------------------------------------------------------
  localparam int IUVW_SW_NONE_BIT = 0;
  localparam int IUVW_SW_INPUT_BIT = 13;
  localparam int IUVW_SI_UV_WARN_BIT = 5;

  typedef logic [15:0] iuvw_code_t;
  typedef logic signed [47:0] iuvw_fix_t;

  // Linear-11 code to signed fixed point, 16 fraction bits
  function automatic iuvw_fix_t iuvw_lin11_fix(input iuvw_code_t code);
    logic signed [5:0] sh;
    iuvw_fix_t y;
    sh = $signed({code[IUVW_EXP_MSB], code[IUVW_EXP_MSB:IUVW_EXP_LSB]}) + IUVW_FIX_FRAC;
    y = $signed({{37{code[IUVW_MANT_MSB]}}, code[IUVW_MANT_MSB:0]});
    return y <<< sh[4:0];
  endfunction : iuvw_lin11_fix

endpackage : iuvw_pkg

// ===== rtl/iuvw_top.sv
// Input low-voltage warning threshold register with status and retry gate
`timescale 1ns/1ps
module iuvw_top (
  input wire logic clk,
  input wire logic sys_rst,
  // Command port
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire iuvw_pkg::iuvw_code_t cmd_wdata,
  input wire logic write_protect,
  output iuvw_pkg::iuvw_code_t cmd_rdata,
  output logic cmd_ack,
  output logic cmd_nak,
  // Stored setting restore
  input wire logic stored_valid,
  input wire iuvw_pkg::iuvw_code_t stored_code,
  // Telemetry
  input wire logic vin_sample_valid,
  input wire iuvw_pkg::iuvw_code_t vin_sample,
  // Status and fault handling
  input wire logic clear_faults,
  input wire logic [7:0] uv_fault_response,
  output logic [15:0] status_word,
  output logic [7:0] status_input,
  output logic alert_n,
  output logic vin_below_warn,
  output logic restart_permit,
  output iuvw_pkg::iuvw_code_t threshold
);
  import iuvw_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    iuvw_code_t thr;
    iuvw_code_t rdata;
    logic ack;
    logic nak;
    logic warn;
    logic below;
    logic above;
    logic permit;
    logic alert_n;
    logic [15:0] sw;
    logic [7:0] si;
  } iuvw_state_t;

  iuvw_state_t st;
  iuvw_state_t next_st;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Only the warning drives these bits; the rest belong to other limits
  function automatic logic [15:0] iuvw_word_bits(input logic warn);
    logic [15:0] w;
    w = 16'h0000;
    w[IUVW_SW_NONE_BIT] = warn;
    w[IUVW_SW_INPUT_BIT] = warn;
    return w;
  endfunction : iuvw_word_bits

  function automatic logic [7:0] iuvw_input_bits(input logic warn);
    logic [7:0] w;
    w = 8'h00;
    w[IUVW_SI_UV_WARN_BIT] = warn;
    return w;
  endfunction : iuvw_input_bits

  function automatic logic iuvw_retry_on(input logic [7:0] resp);
    return (resp[IUVW_RESP_MODE_MSB:IUVW_RESP_MODE_LSB] == IUVW_RESP_MODE_RETRY)
           && (resp[IUVW_RESP_RETRY_MSB:IUVW_RESP_RETRY_LSB] != 3'h0);
  endfunction : iuvw_retry_on

  // ----------------------------------------------------------------
  // Decoders
  // ----------------------------------------------------------------
  iuvw_fix_t wdata_fix;
  iuvw_fix_t thr_fix;
  iuvw_fix_t sample_fix;
  iuvw_fix_t stored_fix;
  logic wdata_ok;
  logic stored_ok;
  // Held code is legal by construction; samples are compared whatever they read

  iuvw_lin11_dec u_dec_wdata (
    .code(cmd_wdata),
    .value(wdata_fix),
    .in_range(wdata_ok)
  );

  iuvw_lin11_dec u_dec_thr (
    .code(st.thr),
    .value(thr_fix),
    .in_range()
  );

  iuvw_lin11_dec u_dec_sample (
    .code(vin_sample),
    .value(sample_fix),
    .in_range()
  );

  iuvw_lin11_dec u_dec_stored (
    .code(stored_code),
    .value(stored_fix),
    .in_range(stored_ok)
  );

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic hit;
  logic wr_hit;
  logic rd_hit;

  always_comb begin
    hit = cmd_valid && (cmd_code == IUVW_CMD_CODE);
    wr_hit = hit && cmd_write;
    rd_hit = hit && !cmd_write;
  end

  // ----------------------------------------------------------------
  // Telemetry decode
  // ----------------------------------------------------------------
  logic retry_mode;
  logic warn_set;

  always_comb begin
    retry_mode = iuvw_retry_on(uv_fault_response);
    warn_set = vin_sample_valid && (sample_fix < thr_fix);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.ack = 1'b0;
    next_st.nak = 1'b0;

    // Stored setting may replace the default, but only a legal one
    if (stored_valid && stored_ok) begin
      next_st.thr = stored_code;
    end

    // ----------------------------------------------------------------
    // Register access
    // ----------------------------------------------------------------
    // Register access; protection and range both refuse the write
    if (wr_hit) begin
      if (!write_protect && wdata_ok) begin
        next_st.thr = cmd_wdata;
        next_st.ack = 1'b1;
      end else begin
        next_st.nak = 1'b1;
      end
    end else if (rd_hit) begin
      next_st.rdata = st.thr;
      next_st.ack = 1'b1;
    end

    // ----------------------------------------------------------------
    // Telemetry
    // ----------------------------------------------------------------
    // Live comparison on every fresh sample
    if (vin_sample_valid) begin
      next_st.below = sample_fix < thr_fix;
      next_st.above = sample_fix > thr_fix;
    end

    // ----------------------------------------------------------------
    // Warning and status
    // ----------------------------------------------------------------
    // Sticky warning; a new event wins over a clear in the same cycle
    if (clear_faults) begin
      next_st.warn = 1'b0;
    end
    if (warn_set) begin
      next_st.warn = 1'b1;
    end

    next_st.sw = iuvw_word_bits(next_st.warn);
    next_st.si = iuvw_input_bits(next_st.warn);
    next_st.alert_n = !next_st.warn;

    // In retry mode, restart held off until a sample reads above the threshold; otherwise always permitted
    // A warning limit below the fault limit would let retries restart too early
    next_st.permit = retry_mode ? next_st.above : 1'b1;

    // ----------------------------------------------------------------
    // Reset
    // ----------------------------------------------------------------
    if (sys_rst) begin
      next_st = '0;
      next_st.thr = IUVW_THR_RESET;
      next_st.alert_n = 1'b1;
      next_st.permit = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    st <= next_st;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    cmd_rdata = st.rdata;
    cmd_ack = st.ack;
    cmd_nak = st.nak;
    status_word = st.sw;
    status_input = st.si;
    alert_n = st.alert_n;
    vin_below_warn = st.below;
    restart_permit = st.permit;
    threshold = st.thr;
  end

endmodule : iuvw_top

// ===== testbench/iuvw_assertions.sv
// Assertion checker for the threshold register block
`timescale 1ns/1ps
module iuvw_assertions (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic write_protect,
  input wire logic cmd_ack,
  input wire logic cmd_nak,
  input wire logic clear_faults,
  input wire logic vin_sample_valid,
  input wire logic alert_n,
  input wire logic vin_below_warn,
  input wire logic restart_permit,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] uv_fault_response,
  input wire logic [7:0] status_input,
  input wire logic [15:0] status_word,
  input wire iuvw_pkg::iuvw_code_t cmd_wdata,
  input wire iuvw_pkg::iuvw_code_t cmd_rdata,
  input wire iuvw_pkg::iuvw_code_t threshold
);
  import iuvw_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence req_s;
    cmd_valid && cmd_code == IUVW_CMD_CODE;
  endsequence
  // Mode change needs a cycle to settle into the gate
  sequence retry_s;
    uv_fault_response[7:6] == 2'h2 && uv_fault_response[5:3] != 3'h0
      && $stable(uv_fault_response);
  endsequence
  a_reset_value: assert property ($fell(sys_rst) |-> threshold == IUVW_THR_RESET)
    else $error("bad reset value");
  a_one_answer: assert property (req_s |=> cmd_ack != cmd_nak)
    else $error("no single answer");
  a_protect_nak: assert property (req_s ##0 cmd_write && write_protect |=> cmd_nak)
    else $error("protected write taken");
  a_nak_keeps: assert property (cmd_nak |-> $stable(threshold))
    else $error("refused write changed value");
  a_write_store: assert property (cmd_ack && $past(cmd_write) |-> threshold == $past(cmd_wdata))
    else $error("write not stored");
  a_read_data: assert property (cmd_ack && !$past(cmd_write) |-> cmd_rdata == $past(threshold))
    else $error("bad read data");
  a_warn_bits: assert property (status_word[13] |-> status_word[0] && status_input[5] && !alert_n)
    else $error("warning bits apart");
  a_sticky_warn: assert property ($fell(status_input[5]) |-> $past(clear_faults))
    else $error("warning dropped");
  a_sample_eval: assert property ($rose(vin_below_warn) |-> $past(vin_sample_valid))
    else $error("below without sample");
  a_retry_gate: assert property (retry_s ##0 restart_permit |-> !vin_below_warn)
    else $error("restart while below");
endmodule : iuvw_assertions

bind iuvw_top iuvw_assertions u_chk (.clk, .sys_rst, .cmd_valid, .cmd_write, .write_protect,
  .cmd_ack, .cmd_nak, .clear_faults, .vin_sample_valid, .alert_n, .vin_below_warn,
  .restart_permit, .cmd_code, .uv_fault_response, .status_input, .status_word, .cmd_wdata,
  .cmd_rdata, .threshold);

// ===== testbench/iuvw_host.sv
// Host model driving the threshold command port
`timescale 1ns/1ps
module iuvw_host (
  input wire logic clk,
  output logic cmd_valid = 1'b0,
  output logic cmd_write = 1'b0,
  output logic write_protect = 1'b0,
  output logic [7:0] cmd_code = 8'h00,
  output iuvw_pkg::iuvw_code_t cmd_wdata = 16'h0000
);
  task issue(input logic wr, wp, input logic [7:0] code, input logic [15:0] d);
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd_write = wr;
    write_protect = wp;
    cmd_code = code;
    cmd_wdata = d;
  endtask : issue
  // Released write data flips so stale data never looks valid
  task idle();
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    cmd_wdata = ~cmd_wdata;
  endtask : idle
endmodule : iuvw_host

// ===== testbench/testbench.sv
// Self-checking bench for the threshold register block
`timescale 1ns/1ps
module testbench;
  import iuvw_pkg::*;
  typedef struct packed {logic wr; logic wp; logic [7:0] code; logic [15:0] d;} iuvw_op_t;
  logic clk = 0, sys_rst = 1, cmd_valid, cmd_write, write_protect, cmd_ack, cmd_nak;
  logic clear_faults = 0, vin_sample_valid = 0, alert_n, vin_below_warn, restart_permit;
  logic stored_valid = 0;
  iuvw_code_t stored_code = 0;
  logic [32:0] got;
  logic [7:0] cmd_code, status_input, uv_fault_response = 8'h80;
  logic [15:0] status_word, y;
  iuvw_code_t cmd_wdata, cmd_rdata, threshold, vin_sample = 0, thr_m = 16'hcb80, rd_m = 0;
  int err_count = 0, check_count = 0, seed = 32'h4e11;
  logic sticky = 0, sp = 0, s;
  logic [33:0] q[$];
  logic [33:0] e;
  // 6.75 V stays above the fault level; boundary and refused codes follow
  iuvw_op_t ops[10] = '{'{0, 0, 8'h58, 16'h0}, '{1, 0, 8'h58, 16'hcb60},
    '{1, 1, 8'h58, 16'hcbc0}, '{1, 0, 8'h58, 16'hcc00}, '{1, 0, 8'h58, 16'h0010},
    '{1, 0, 8'h58, 16'he101}, '{0, 0, 8'h58, 16'h0}, '{0, 0, 8'h57, 16'h0},
    '{1, 0, 8'h58, 16'hcb80}, '{0, 0, 8'h58, 16'h0}};
  always #10 clk = ~clk;
  iuvw_host host (.clk, .cmd_valid, .cmd_write, .write_protect, .cmd_code, .cmd_wdata);
  iuvw_top dut (.clk, .sys_rst, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata, .write_protect,
    .cmd_rdata, .cmd_ack, .cmd_nak, .stored_valid, .stored_code,
    .vin_sample_valid, .vin_sample, .clear_faults, .uv_fault_response, .status_word,
    .status_input, .alert_n, .vin_below_warn, .restart_permit, .threshold);
  function automatic logic in_range(input logic [15:0] d);
    real v;
    v = $signed(d[10:0]) * 2.0 ** $signed(d[15:11]);
    return v >= 0.0 && v <= 16.0;
  endfunction : in_range
  task check(input string name, input logic [32:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task final_report();
    if (err_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  always @(posedge clk) begin
    s = vin_sample_valid;
    #2;
    if (!sys_rst && (cmd_ack || cmd_nak || sp)) begin
      e = q.size() ? q.pop_front() : 34'h1;
      got = {6'h0, status_word, status_input, alert_n, vin_below_warn, restart_permit};
      if (e[33]) check("status", got, e[32:0]);
      else check("command", {cmd_nak, threshold, cmd_rdata}, e[32:0]);
    end
    sp = s;
  end
  initial begin
    repeat (8) @(posedge clk);
    #1;
    sys_rst = 0;
    foreach (ops[i]) begin
      if (ops[i].code == IUVW_CMD_CODE) begin
        if (!ops[i].wr) rd_m = thr_m;
        else if (!ops[i].wp && in_range(ops[i].d)) thr_m = ops[i].d;
        q.push_back({1'b0, ops[i].wr && (ops[i].wp || !in_range(ops[i].d)), thr_m, rd_m});
      end
      host.issue(ops[i].wr, ops[i].wp, ops[i].code, ops[i].d);
    end
    host.idle();
    // Restore: illegal code ignored, legal code taken and read back, then default again
    @(posedge clk);
    #1;
    stored_valid = 1;
    stored_code = 16'hcc00;
    @(posedge clk);
    #1;
    stored_code = 16'hcb60;
    @(posedge clk);
    #1;
    stored_valid = 0;
    q.push_back({2'b0, 16'hcb60, 16'hcb60});
    host.issue(0, 0, IUVW_CMD_CODE, 16'h0);
    host.idle();
    stored_valid = 1;
    stored_code = IUVW_THR_RESET;
    @(posedge clk);
    #1;
    stored_valid = 0;
    for (int i = 0; i < 16; i++) begin
      y = 16'($random(seed)) & 16'h03ff;
      // One sample on the threshold, and some above it so the retry gate opens
      if (i == 5) y = 16'h0380;
      if (i % 8 == 7) y = 16'h0381;
      if (i % 4 == 0) begin
        @(posedge clk);
        #1;
        clear_faults = 1;
        @(posedge clk);
        #1;
        clear_faults = 0;
        sticky = 0;
      end
      uv_fault_response = i < 8 ? 8'h80 : 8'h98;
      @(posedge clk);
      #1;
      vin_sample = 16'hc800 | y;
      vin_sample_valid = 1;
      sticky |= y < 16'h0380;
      q.push_back({1'b1, 6'h0, sticky ? 16'h2001 : 16'h0, sticky ? 8'h20 : 8'h0, !sticky,
        y < 16'h0380, i < 8 || y > 16'h0380});
      @(posedge clk);
      #1;
      vin_sample_valid = 0;
    end
    repeat (3) @(posedge clk);
    check("pending", q.size(), 0);
    final_report();
  end
  initial begin
    #20000;
    err_count++;
    final_report();
  end
endmodule : testbench
